// File: pkg/rlc_pkg.sv
/*
 * Constants and types for the record level control and noise gate.
 * Assumes a 48 kHz sample strobe and a 32-bit AHB-Lite register bus.
 */
package rlc_pkg;
    // =========================================================
    // Timing
    localparam int unsigned SAMPLE_HZ = 48000;
    localparam int unsigned GATE_WAIT_MS = 250;
    localparam int unsigned GATE_WAIT_SMP = GATE_WAIT_MS * SAMPLE_HZ / 1000;
    localparam int unsigned FADE_MS = 100;
    localparam int unsigned FADE_SMP = FADE_MS * SAMPLE_HZ / 1000;
    localparam int unsigned ACC_W = 14;
    localparam logic [13:0] FADE_STEP = 14'((2 ** ACC_W + FADE_SMP - 1) / FADE_SMP);
    localparam logic [23:0] ATK_BASE = 24'h000001;
    localparam logic [23:0] DEC_BASE = 24'h000010;
    localparam logic [23:0] HOLD_BASE = 24'h000040;
    localparam logic [4:0] TARG_OFS = 5'h08;
    // =========================================================
    // Register indices (byte address is four times the index)
    localparam logic [15:0] IDX_CTL0 = 16'h4011;
    localparam logic [15:0] IDX_CTL1 = 16'h4012;
    localparam logic [15:0] IDX_CTL2 = 16'h4013;
    localparam logic [15:0] IDX_GATE = 16'h4014;
    localparam logic [15:0] IDX_MAN_L = 16'h4015;
    localparam logic [15:0] IDX_MAN_R = 16'h4016;
    localparam logic [15:0] IDX_STAT = 16'h4017;
    localparam int unsigned NREG = 6;
    localparam logic [7:0] RST_CTL0 = 8'h70;
    localparam logic [7:0] RST_CTL1 = 8'h44;
    localparam logic [7:0] RST_CTL2 = 8'h48;
    localparam logic [7:0] RST_GATE = 8'h00;
    localparam logic [7:0] RST_MAN_L = 8'h10;
    localparam logic [7:0] RST_MAN_R = 8'h10;
    localparam logic [47:0] RST_VALS = {RST_MAN_R, RST_MAN_L, RST_GATE,
                                        RST_CTL2, RST_CTL1, RST_CTL0};
    // =========================================================
    // Field positions
    localparam int unsigned SEL_LSB = 0;
    localparam int unsigned CEIL_LSB = 4;
    localparam int unsigned TARG_LSB = 0;
    localparam int unsigned ATK_LSB = 4;
    localparam int unsigned HOLD_LSB = 0;
    localparam int unsigned DEC_LSB = 4;
    localparam int unsigned THR_LSB = 0;
    localparam int unsigned GEN_BIT = 5;
    localparam int unsigned GTYP_LSB = 6;
    localparam int unsigned STAT_PGA_R_LSB = 8;
    localparam int unsigned STAT_GST_LSB = 16;
    localparam int unsigned STAT_MUTE_BIT = 20;
    // =========================================================
    // Encodings
    localparam logic [2:0] SEL_LEFT = 3'h1;
    localparam logic [2:0] SEL_RIGHT = 3'h2;
    localparam logic [2:0] SEL_STEREO = 3'h3;
    localparam logic [2:0] SEL_DSP = 3'h4;
    localparam logic [1:0] GT_FREEZE = 2'h0;
    localparam logic [1:0] GT_MUTE = 2'h1;
    localparam logic [1:0] GT_FADE = 2'h2;
    localparam logic [1:0] GT_FADE_MUTE = 2'h3;
    typedef enum logic [1:0] {G_OPEN, G_SHUT, G_FADE, G_DONE} rlc_gate_t;
endpackage

// File: rtl/rlc_top.sv
/*
 * Record level control loop with noise gate and AHB-Lite registers.
 * Assumes samples and processor gain arrive on ref_clk; smp_valid is one
 * cycle per audio sample.
 */
`timescale 1ns/100ps
// Behaviour
// - Select field enables loop, picks mode
// - Stereo: louder channel drives shared gain
// - Processor mode: processor sets amplifier gain
// - Four-bit target recording level
// - Attack field sets gain reduction rate
// - Raise gain only after hold time
// - Decay field sets gain raise rate
// - Loop gain clamped to ceiling field; manual and processor gains are not
// - Gain bounded at amplifier minimum
// - Enabled gate acts below threshold
// - Five-bit gate closing threshold
// - Gate closes after 250 ms below
// - Gate opens 6 dB above close
// - Type 00 freezes gain
// - Type 01 mutes converter output
// - Type 10 fades gain, no mute
// - Type 11 fades then mutes
// - Level measured from converter samples
// - Gain moves in tiny steps
module rlc_top import rlc_pkg::*; #(
    parameter int unsigned GATE_WAIT = GATE_WAIT_SMP
) (
    input logic ref_clk,
    input logic rst_b,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input logic smp_valid,
    input logic [23:0] smp_l,
    input logic [23:0] smp_r,
    input logic [5:0] proc_gain_l,
    input logic [5:0] proc_gain_r,
    output logic [5:0] pga_gain_l,
    output logic [5:0] pga_gain_r,
    output logic out_valid,
    output logic [23:0] out_l,
    output logic [23:0] out_r,
    output logic gate_mute
);
    // =========================================================
    // Helpers
    function automatic logic loop_mode(input logic [2:0] s);
        return (s == SEL_LEFT) || (s == SEL_RIGHT) || (s == SEL_STEREO);
    endfunction

    // Octave level: 6 dB per step, 0 for silence
    function automatic logic [4:0] level_of(input logic [23:0] x);
        logic [23:0] m;
        logic [4:0] l;
        m = x[23] ? ~x : x;
        l = 5'h00;
        for (int i = 0; i < 24; i++) begin
            if (m[i]) begin
                l = 5'(i + 1);
            end
        end
        return l;
    endfunction

    function automatic logic [23:0] interval(input logic [23:0] b, input logic [3:0] f);
        return b << f;
    endfunction

    // =========================================================
    // Register bus
    logic [7:0] reg_r [NREG];
    logic wr_pend_r;
    logic [15:0] wr_idx_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_nxt;
    logic ap;
    logic [15:0] a_idx;

    assign ap = hsel && hready && htrans[1];
    assign a_idx = haddr[17:2];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= 16'h0000;
        end else if (hready) begin
            wr_pend_r <= ap && hwrite && (hsize == 3'h2);
            wr_idx_r <= a_idx;
        end
    end

    for (genvar g = 0; g < NREG; g++) begin : g_reg
        always_ff @(posedge ref_clk) begin
            if (!rst_b) begin
                reg_r[g] <= RST_VALS[g*8 +: 8];
            end else if (wr_pend_r && wr_idx_r == IDX_CTL0 + 16'(g)) begin
                reg_r[g] <= hwdata[7:0];
            end
        end
    end

    logic [2:0] sel;
    logic [2:0] ceil;
    logic [3:0] targ, atk, hold, dec;
    logic [4:0] thr;
    logic gen;
    logic [1:0] gtyp;
    logic [5:0] man_l, man_r;
    assign sel = reg_r[0][SEL_LSB +: 3];
    assign ceil = reg_r[0][CEIL_LSB +: 3];
    assign targ = reg_r[1][TARG_LSB +: 4];
    assign atk = reg_r[1][ATK_LSB +: 4];
    assign hold = reg_r[2][HOLD_LSB +: 4];
    assign dec = reg_r[2][DEC_LSB +: 4];
    assign thr = reg_r[3][THR_LSB +: 5];
    assign gen = reg_r[3][GEN_BIT];
    assign gtyp = reg_r[3][GTYP_LSB +: 2];
    assign man_l = reg_r[4][5:0];
    assign man_r = reg_r[5][5:0];

    rlc_gate_t gst;
    logic [5:0] pga_l_r, pga_r_r;
    logic mute_r;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (a_idx >= IDX_CTL0 && a_idx < IDX_STAT) begin
            if (wr_pend_r && wr_idx_r == a_idx) begin
                rd_nxt[7:0] = hwdata[7:0];
            end else begin
                rd_nxt[7:0] = reg_r[3'(a_idx - IDX_CTL0)];
            end
        end else if (a_idx == IDX_STAT) begin
            rd_nxt[5:0] = pga_l_r;
            rd_nxt[STAT_PGA_R_LSB +: 6] = pga_r_r;
            rd_nxt[STAT_GST_LSB +: 2] = gst;
            rd_nxt[STAT_MUTE_BIT] = mute_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            hrdata_r <= 32'h0000_0000;
        end else if (ap && !hwrite) begin
            hrdata_r <= rd_nxt;
        end
    end

    // =========================================================
    // Level measurement
    logic [4:0] lvl_l, lvl_r, lvl_g, lvl_c, tgt;
    logic loop_on;
    assign lvl_l = level_of(smp_l);
    assign lvl_r = level_of(smp_r);
    assign lvl_g = (lvl_l > lvl_r) ? lvl_l : lvl_r;
    assign lvl_c = (sel == SEL_LEFT) ? lvl_l : (sel == SEL_RIGHT) ? lvl_r : lvl_g;
    assign tgt = 5'(targ) + TARG_OFS;
    assign loop_on = loop_mode(sel);

    // =========================================================
    // Noise gate
    logic [15:0] below_cnt;
    logic [13:0] acc_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            gst <= G_OPEN;
            below_cnt <= 16'h0000;
        end else if (!gen) begin
            gst <= G_OPEN;
            below_cnt <= 16'h0000;
        end else if (smp_valid) begin
            unique case (gst)
                G_OPEN: begin
                    if (lvl_g < thr) begin
                        if (below_cnt == 16'(GATE_WAIT - 1)) begin
                            below_cnt <= 16'h0000;
                            gst <= gtyp[1] ? G_FADE : G_SHUT;
                        end else begin
                            below_cnt <= below_cnt + 16'h0001;
                        end
                    end else begin
                        below_cnt <= 16'h0000;
                    end
                end
                G_SHUT, G_DONE: begin
                    if (lvl_g > thr) begin
                        gst <= G_OPEN;
                    end
                end
                G_FADE: begin
                    if (lvl_g > thr) begin
                        gst <= G_OPEN;
                    end else if (acc_r == 14'h0000 || !loop_on) begin
                        gst <= G_DONE;
                    end
                end
            endcase
        end
    end

    // =========================================================
    // Gain loop: 6 integer bits, 8 fraction bits
    logic [23:0] hold_r, tick_r, atk_int, dec_int, hold_int;
    logic [13:0] ceil_acc;
    logic frozen;
    assign atk_int = interval(ATK_BASE, atk);
    assign dec_int = interval(DEC_BASE, dec);
    assign hold_int = interval(HOLD_BASE, hold);
    assign ceil_acc = {ceil, 3'h7, 8'h00};
    assign frozen = (gst == G_SHUT) && (gtyp == GT_FREEZE);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            acc_r <= 14'h0000;
            hold_r <= 24'h000000;
            tick_r <= 24'h000000;
        end else if (!loop_on) begin
            acc_r <= {man_l, 8'h00};
            hold_r <= 24'h000000;
            tick_r <= 24'h000000;
        end else if (acc_r > ceil_acc) begin
            acc_r <= ceil_acc;
        end else if (smp_valid && !frozen) begin
            if (gst == G_FADE) begin
                acc_r <= (acc_r > FADE_STEP) ? acc_r - FADE_STEP : 14'h0000;
            end else if (gst == G_DONE) begin
                acc_r <= 14'h0000;
            end else if (lvl_c > tgt) begin
                hold_r <= 24'h000000;
                if (tick_r >= atk_int - 24'h000001) begin
                    tick_r <= 24'h000000;
                    if (acc_r != 14'h0000) begin
                        acc_r <= acc_r - 14'h0001;
                    end
                end else begin
                    tick_r <= tick_r + 24'h000001;
                end
            end else if (lvl_c < tgt) begin
                if (hold_r < hold_int) begin
                    hold_r <= hold_r + 24'h000001;
                end else if (tick_r >= dec_int - 24'h000001) begin
                    tick_r <= 24'h000000;
                    if (acc_r < ceil_acc) begin
                        acc_r <= acc_r + 14'h0001;
                    end
                end else begin
                    tick_r <= tick_r + 24'h000001;
                end
            end else begin
                hold_r <= 24'h000000;
                tick_r <= 24'h000000;
            end
        end
    end

    // =========================================================
    // Amplifier gain outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pga_l_r <= 6'h00;
            pga_r_r <= 6'h00;
        end else begin
            case (sel)
                SEL_LEFT: begin
                    pga_l_r <= acc_r[13:8];
                    pga_r_r <= man_r;
                end
                SEL_RIGHT: begin
                    pga_l_r <= man_l;
                    pga_r_r <= acc_r[13:8];
                end
                SEL_STEREO: begin
                    pga_l_r <= acc_r[13:8];
                    pga_r_r <= acc_r[13:8];
                end
                SEL_DSP: begin
                    pga_l_r <= proc_gain_l;
                    pga_r_r <= proc_gain_r;
                end
                default: begin
                    pga_l_r <= man_l;
                    pga_r_r <= man_r;
                end
            endcase
        end
    end
    assign pga_gain_l = pga_l_r;
    assign pga_gain_r = pga_r_r;

    // =========================================================
    // Digital mute of converter output
    logic mute_now, out_vld_r;
    logic [23:0] out_l_r, out_r_r;
    assign mute_now = gen && (((gst == G_SHUT) && (gtyp == GT_MUTE))
                      || ((gst == G_DONE) && (gtyp == GT_FADE_MUTE)));

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mute_r <= 1'b0;
            out_vld_r <= 1'b0;
            out_l_r <= 24'h000000;
            out_r_r <= 24'h000000;
        end else begin
            mute_r <= mute_now;
            out_vld_r <= smp_valid;
            if (smp_valid) begin
                out_l_r <= mute_now ? 24'h000000 : smp_l;
                out_r_r <= mute_now ? 24'h000000 : smp_r;
            end
        end
    end
    assign out_valid = out_vld_r;
    assign out_l = out_l_r;
    assign out_r = out_r_r;
    assign gate_mute = mute_r;

    // =========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_ceiling;
        loop_on |=> acc_r <= $past(ceil_acc);
    endproperty
    a_ceiling: assert property (p_ceiling) else $error("gain above ceiling");
    property p_floor;
        loop_on && acc_r == 14'h0000 |=> acc_r < 14'h0100;
    endproperty
    a_floor: assert property (p_floor) else $error("gain wrapped below minimum");
    property p_off;
        !loop_on && sel != SEL_DSP |=> pga_l_r == $past(man_l) && pga_r_r == $past(man_r)
            && hold_r == 24'h000000;
    endproperty
    a_off: assert property (p_off) else $error("disabled loop moved gain");
    property p_dsp;
        sel == SEL_DSP |=> pga_l_r == $past(proc_gain_l) && pga_r_r == $past(proc_gain_r);
    endproperty
    a_dsp: assert property (p_dsp) else $error("processor gain not applied");
    property p_stereo;
        sel == SEL_STEREO |=> pga_l_r == pga_r_r;
    endproperty
    a_stereo: assert property (p_stereo) else $error("stereo gains differ");
    property p_gate_wait;
        gst == G_OPEN ##1 gst != G_OPEN |-> $past(below_cnt) == 16'(GATE_WAIT - 1);
    endproperty
    a_gate_wait: assert property (p_gate_wait) else $error("gate closed early");
    property p_release;
        gen && gst != G_OPEN ##1 gen && gst == G_OPEN |-> $past(lvl_g) > $past(thr);
    endproperty
    a_release: assert property (p_release) else $error("gate opened below hysteresis");
    property p_freeze;
        frozen && loop_on && acc_r <= ceil_acc |=> acc_r == $past(acc_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen gain changed");
    property p_mute;
        mute_now && smp_valid |=> out_vld_r && out_l_r == 24'h000000 && out_r_r == 24'h000000;
    endproperty
    a_mute: assert property (p_mute) else $error("muted sample passed");
    property p_fade_nomute;
        gtyp == GT_FADE |=> !mute_r;
    endproperty
    a_fade_nomute: assert property (p_fade_nomute) else $error("fade type muted");
    property p_hold;
        loop_on && $past(loop_on) && acc_r > $past(acc_r) |-> $past(hold_r) >= $past(hold_int);
    endproperty
    a_hold: assert property (p_hold) else $error("gain raised before hold");
    property p_step;
        loop_on && $past(loop_on) && acc_r > $past(acc_r) |-> acc_r - $past(acc_r) == 14'h0001;
    endproperty
    a_step: assert property (p_step) else $error("gain step too large");

    c_shut: cover property (gst == G_OPEN ##1 gst == G_SHUT);
    c_fade_done: cover property (gst == G_FADE ##1 gst == G_DONE);
    c_attack: cover property (loop_on ##1 loop_on && acc_r < $past(acc_r));
    c_mute: cover property ($rose(mute_r));
endmodule // rlc_top

// File: verification/rlc_adc_model.sv
/*
 * Converter-side model: sends stereo sample pairs at a fixed spacing.
 * Assumes the bench picks the level of each channel and gates the stream.
 */
`timescale 1ns/100ps
module rlc_adc_model #(
    parameter int unsigned SPACING = 2
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic smp_en,
    input wire logic [4:0] lvl_l,
    input wire logic [4:0] lvl_r,
    output logic smp_valid,
    output logic [23:0] smp_l,
    output logic [23:0] smp_r
);
    int unsigned cnt = 0;
    logic fire;

    // Highest magnitude bit at the level, random bits below it
    function automatic logic [23:0] mk(input logic [4:0] lvl);
        logic [23:0] top;
        top = (lvl == 5'h00) ? 24'h000000 : 24'h000001 << (lvl - 5'h01);
        return top | (24'($urandom) & (top - 24'h000001) & {24{lvl != 5'h00}});
    endfunction

    assign fire = rst_b && smp_en && (cnt == SPACING - 1);

    initial begin
        smp_valid = 1'b0;
        smp_l = 24'h000000;
        smp_r = 24'h000000;
    end

    always @(posedge ref_clk) begin
        if (!rst_b || !smp_en) begin
            cnt <= 0;
        end else begin
            cnt <= (cnt == SPACING - 1) ? 0 : cnt + 1;
        end
        smp_valid <= fire;
        if (fire) begin
            smp_l <= mk(lvl_l);
            smp_r <= mk(lvl_r);
        end else begin
            // Idle lines never keep the last sample
            smp_l <= ~smp_l;
            smp_r <= ~smp_r;
        end
    end
endmodule // rlc_adc_model

// File: verification/testbench.sv
/*
 * Self-checking bench for the record level control and noise gate.
 * Assumes rlc_pkg and the converter model; reads are checked from a queue.
 */
`timescale 1ns/100ps
module testbench import rlc_pkg::*; ;
    localparam int unsigned GATE_N = 8;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    wire logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic smp_en = 1'b0;
    logic [4:0] lvl_l = 5'h00;
    logic [4:0] lvl_r = 5'h00;
    logic smp_valid;
    logic [23:0] smp_l;
    logic [23:0] smp_r;
    logic [5:0] proc_gain_l = 6'h00;
    logic [5:0] proc_gain_r = 6'h00;
    logic [5:0] pga_gain_l;
    logic [5:0] pga_gain_r;
    logic out_valid;
    logic [23:0] out_l;
    logic [23:0] out_r;
    logic gate_mute;
    logic rd_dp = 1'b0;
    logic exp_care = 1'b1;
    logic exp_mute = 1'b0;
    logic [31:0] q_rd[$];
    logic [49:0] q_smp[$];
    int bad_count = 0;
    int tests_run = 0;

    assign hready = hreadyout;
    always #4 ref_clk = ~ref_clk;

    rlc_top #(.GATE_WAIT(GATE_N)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .smp_valid(smp_valid), .smp_l(smp_l), .smp_r(smp_r), .proc_gain_l(proc_gain_l),
        .proc_gain_r(proc_gain_r), .pga_gain_l(pga_gain_l), .pga_gain_r(pga_gain_r),
        .out_valid(out_valid), .out_l(out_l), .out_r(out_r), .gate_mute(gate_mute));

    rlc_adc_model #(.SPACING(2)) i_adc (.ref_clk(ref_clk), .rst_b(rst_b), .smp_en(smp_en),
        .lvl_l(lvl_l), .lvl_r(lvl_r), .smp_valid(smp_valid), .smp_l(smp_l), .smp_r(smp_r));

    // ==========================================================
    // Compare and report
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t read exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic chk_smp(input logic [49:0] e, input logic [48:0] g);
        if (e[49] === 1'b1) begin
            tests_run++;
            if (g !== e[48:0]) begin
                bad_count++;
                $display("BAD t=%0t sample exp=%h got=%h", $time, e[48:0], g);
            end
        end
    endtask

    always @(posedge ref_clk) begin
        if (smp_valid === 1'b1) begin
            q_smp.push_back({exp_care, exp_mute, exp_mute ? 48'h0 : {smp_l, smp_r}});
        end
        if (out_valid === 1'b1) begin
            chk_smp(q_smp.size() != 0 ? q_smp.pop_front() : {1'b1, ~gate_mute, ~out_l, ~out_r},
                {gate_mute, out_l, out_r});
        end
        if (rd_dp === 1'b1 && hready === 1'b1) begin
            chk_rd(q_rd.size() != 0 ? q_rd.pop_front() : ~hrdata, hrdata);
        end
    end

    // ==========================================================
    // Bus and stream drivers
    task automatic ahb(input logic [15:0] idx, input logic wr_en, input logic [2:0] sz,
            input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {14'h0000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr_en;
        hsize <= sz;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !wr_en;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd_dp <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        ahb(idx, 1'b1, 3'h2, {24'h000000, d});
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] e);
        q_rd.push_back(e);
        ahb(idx, 1'b0, 3'h2, 32'h00000000);
    endtask

    function automatic logic [31:0] stat(input logic [5:0] l, input logic [5:0] r,
            input logic [1:0] st, input logic m);
        return {11'h000, m, 2'h0, st, 2'h0, r, 2'h0, l};
    endfunction

    task automatic rds(input logic [31:0] e);
        repeat (4) @(posedge ref_clk);
        chk_rd({20'h0, e[13:8], e[5:0]}, {20'h0, pga_gain_r, pga_gain_l});
        rd(IDX_STAT, e);
    endtask

    task automatic send(input int n, input logic [4:0] ll, input logic [4:0] lr,
            input logic care, input logic mute);
        int k = 0;
        @(posedge ref_clk);
        lvl_l <= ll;
        lvl_r <= lr;
        exp_care <= care;
        exp_mute <= mute;
        smp_en <= 1'b1;
        while (k < n) begin
            @(posedge ref_clk);
            if (smp_valid === 1'b1) k++;
        end
        smp_en <= 1'b0;
    endtask

    task automatic do_reset();
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        int unsigned s;
        logic [7:0] v;
        logic [5:0] g;
        s = $urandom(32'h2ef1);
        do_reset();
        for (int i = 0; i < NREG; i++) rd(IDX_CTL0 + 16'(i), {24'h0, RST_VALS[i*8 +: 8]});
        rd(IDX_STAT, stat(6'h10, 6'h10, 2'h0, 1'b0));
        rd(16'h4010, 32'h00000000);
        v = 8'($urandom);
        wr(IDX_GATE, v);
        rd(IDX_GATE, {24'h0, v});
        ahb(IDX_GATE, 1'b1, 3'h0, 32'h000000FF);
        rd(IDX_GATE, {24'h0, v});
        wr(IDX_STAT, 8'hFF);
        rd(IDX_STAT, stat(6'h10, 6'h10, 2'h0, 1'b0));
        wr(16'h4018, 8'h5A);
        rd(16'h4018, 32'h00000000);
        g = 6'($urandom) | 6'h08;
        wr(IDX_MAN_L, {2'h0, g});
        for (int i = 0; i < 8; i++) begin
            if (i == 0 || i > 4) begin
                wr(IDX_CTL0, 8'h70 | 8'(i));
                rds(stat(g, 6'h10, 2'h0, 1'b0));
            end
        end
        proc_gain_l <= 6'($urandom);
        proc_gain_r <= 6'($urandom);
        wr(IDX_CTL0, 8'h74);
        rds(stat(proc_gain_l, proc_gain_r, 2'h0, 1'b0));
        wr(IDX_CTL0, 8'h01);
        rds(stat(6'h07, 6'h10, 2'h0, 1'b0));
        wr(IDX_CTL0, 8'h02);
        rds(stat(g, 6'h07, 2'h0, 1'b0));
        do_reset();
        wr(IDX_CTL1, 8'h04);
        wr(IDX_CTL0, 8'h73);
        send(2000, 5'h03, 5'h17, 1'b1, 1'b0);
        rds(stat(6'h08, 6'h08, 2'h0, 1'b0));
        send(2200, 5'h03, 5'h17, 1'b1, 1'b0);
        rds(stat(6'h00, 6'h00, 2'h0, 1'b0));
        do_reset();
        wr(IDX_GATE, 8'h6A);
        send(GATE_N - 1, 5'h02, 5'h02, 1'b1, 1'b0);
        send(1, 5'h0B, 5'h0B, 1'b1, 1'b0);
        send(GATE_N - 1, 5'h02, 5'h02, 1'b1, 1'b0);
        send(1, 5'h02, 5'h02, 1'b0, 1'b0);
        send(3, 5'h02, 5'h02, 1'b1, 1'b1);
        send(2, 5'h0A, 5'h0A, 1'b1, 1'b1);
        send(1, 5'h0B, 5'h0B, 1'b0, 1'b0);
        send(3, 5'h0B, 5'h0B, 1'b1, 1'b0);
        rds(stat(6'h10, 6'h10, 2'h0, 1'b0));
        do_reset();
        wr(IDX_CTL2, 8'h00);
        wr(IDX_CTL0, 8'h73);
        send(64 + 16 * 256, 5'h02, 5'h02, 1'b1, 1'b0);
        rds(stat(6'h11, 6'h11, 2'h0, 1'b0));
        do_reset();
        wr(IDX_CTL2, 8'h0F);
        wr(IDX_CTL0, 8'h73);
        wr(IDX_GATE, 8'h2A);
        send(GATE_N + 2, 5'h02, 5'h02, 1'b1, 1'b0);
        wr(IDX_CTL2, 8'h00);
        send(4600, 5'h02, 5'h02, 1'b1, 1'b0);
        rds(stat(6'h10, 6'h10, 2'h1, 1'b0));
        for (int t = 2; t < 4; t++) begin
            do_reset();
            wr(IDX_CTL0, 8'h73);
            wr(IDX_GATE, {2'(t), 6'h2A});
            send(GATE_N + 500, 5'h02, 5'h02, 1'b1, 1'b0);
            rds(stat(6'h08, 6'h08, 2'h2, 1'b0));
            send(600, 5'h02, 5'h02, t == 2, 1'b0);
            send(20, 5'h02, 5'h02, 1'b1, t == 3);
            rds(stat(6'h00, 6'h00, 2'h3, t == 3));
        end
        repeat (5) @(posedge ref_clk);
        if (q_rd.size() != 0 || q_smp.size() != 0) bad_count++;
        conclude();
    end

    initial begin
        #400000;
        bad_count++;
        conclude();
    end
endmodule // testbench
